/* hdl/pkt_port_pkg.sv */
// constants shared by both ends of the host packet port
package pkt_port_pkg;

  // ****************************************
  // fifo geometry
  // ****************************************
  localparam int          TX_DEPTH = 16;
  localparam int          TX_AW    = 4;
  localparam int          RX_DEPTH = 32;
  localparam int          RX_AW    = 5;

  // ****************************************
  // in-band word fields
  // ****************************************
  localparam int          LEN_MSB       = 15;
  localparam int          INFO_MSB      = 23;
  localparam int          STAT_PAD_LSB  = 3;
  localparam int          STAT_UFL_BIT  = 2;
  localparam int          STAT_TAIL_BIT = 1;
  localparam int          STAT_CRC_BIT  = 0;
  localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;

  // ****************************************
  // apb register map of the host controller
  // ****************************************
  localparam logic [7:0]  STATUS_OFS   = 8'h00;
  localparam logic [7:0]  TX_FIFO_OFS  = 8'h04;
  localparam logic [7:0]  RX_FIFO_OFS  = 8'h08;
  localparam int          ST_TX_READY_FLAG_BIT = 0;
  localparam int          ST_RX_READY_FLAG_BIT = 1;
  localparam int          ST_EOT_BIT   = 2;

  typedef enum logic [1:0] {
    TXP_LEN  = 2'b00,
    TXP_MASK = 2'b01,
    TXP_DATA = 2'b10
  } tx_parse_t;

  typedef enum logic [1:0] {
    RXB_HEAD = 2'b00,
    RXB_DATA = 2'b01,
    RXB_PAD  = 2'b10,
    RXB_STAT = 2'b11
  } rx_build_t;

  typedef enum logic [1:0] {
    HC_IDLE = 2'b00,
    HC_READ = 2'b01
  } host_state_t;

  // byte order swap for big endian hosts
  function automatic logic [31:0] byte_swap(input logic [31:0] w, input logic big);
    byte_swap = big ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction : byte_swap

endpackage : pkt_port_pkg

/* hdl/host_packet_port_if.sv */
// word port between host bus controller and packet port device
`timescale 1ns/1ps
interface host_packet_port_if;
  logic        wr_en;
  logic [31:0] wr_data;
  logic        rd_en;
  logic [31:0] rd_data;
  logic        rd_valid;
  logic        tx_ready_pin_n;
  logic        rx_request_pin;
  logic        rx_end_pin;

  modport dev (
    input  wr_en, wr_data, rd_en,
    output rd_data, rd_valid, tx_ready_pin_n, rx_request_pin, rx_end_pin
  );
  modport host (
    output wr_en, wr_data, rd_en,
    input  rd_data, rd_valid, tx_ready_pin_n, rx_request_pin, rx_end_pin
  );
endinterface : host_packet_port_if

/* hdl/packet_port_device.sv */
// packet port device: tx word fifo toward switch, rx word fifo toward host
// Behaviour
// R1 - slave only; host moves every word
// R2 - host checks tx ready before writing
// R3 - host writes length, mask, then payload
// R4 - host pads last transmit payload word
// R5 - rx ready set while receive data waits
// R6 - frame end flagged by status bit, pin
// R7 - next-to-last word is padded last data; with pad_64 and an odd payload count the code puts a zero pad word there
// R8 - final word is frame status word
// R9 - tx_ready_pin_n low while fifo has room
// R10 - dma writes only while tx ready
// R11 - rx_request_pin high while word available
// R12 - rx_end_pin asserted while status word read
// R13 - selectable 32 or 64 bit padding
// R14 - request drops at read when queue empty
// R15 - request drops with end pin and data
// R16 - endianness only moves payload bytes
// R17 - control words identical in both orders
// R18 - status word padding, underflow, tail, crc
// R19 - header word port, action, priority, vlan
// R20 - second word always mask, ignored normal
// R21 - full fifo drops writes, queue intact
// R22 - empty read returns zero, queue unchanged
//
// Design decisions made here: the register offsets and the APB register port.
`timescale 1ns/1ps
module packet_port_device
  import pkt_port_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // host side
  host_packet_port_if.dev  hp,
  // configuration
  input  wire logic        big_endian,
  input  wire logic        pad_64,
  input  wire logic        normal_forward,
  // frames toward switch
  output logic             tx_out_valid,
  input  wire logic        tx_out_ready,
  output logic [31:0]      tx_out_data,
  output logic             tx_out_last,
  output logic [15:0]      tx_out_len,
  output logic [31:0]      tx_out_dest_mask,
  // frames from switch
  input  wire logic        rx_in_valid,
  output logic             rx_in_ready,
  input  wire logic [31:0] rx_in_data,
  input  wire logic        rx_in_last,
  input  wire logic [1:0]  rx_in_invalid_bytes,
  input  wire logic [23:0] rx_in_info,
  input  wire logic [2:0]  rx_in_err
);

  // ****************************************
  // transmit fifo
  // ****************************************
  logic [31:0]      tx_mem [TX_DEPTH];
  logic [TX_AW-1:0] tx_wp_reg;
  logic [TX_AW-1:0] tx_rp_reg;
  logic [TX_AW:0]   tx_cnt_reg;
  logic [TX_AW:0]   tx_cnt_next;
  logic             tx_push;
  logic             tx_pop;
  logic [31:0]      tx_head;
  tx_parse_t        txp_reg;
  logic [13:0]      tx_left_reg;
  logic             tx_slot_free;

  assign tx_push      = hp.wr_en && (tx_cnt_reg != TX_DEPTH[TX_AW:0]); // R21
  assign tx_head      = tx_mem[tx_rp_reg];
  assign tx_slot_free = !tx_out_valid || tx_out_ready;
  assign tx_pop       = (tx_cnt_reg != '0) && ((txp_reg != TXP_DATA) || tx_slot_free);
  assign tx_cnt_next  = tx_cnt_reg + {{TX_AW{1'b0}}, tx_push} - {{TX_AW{1'b0}}, tx_pop};

  always_ff @(posedge clk) begin
    if (tx_push) begin
      tx_mem[tx_wp_reg] <= hp.wr_data;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      tx_wp_reg  <= '0;
      tx_rp_reg  <= '0;
      tx_cnt_reg <= '0;
    end else begin
      tx_wp_reg  <= tx_wp_reg + TX_AW'(tx_push);
      tx_rp_reg  <= tx_rp_reg + TX_AW'(tx_pop);
      tx_cnt_reg <= tx_cnt_next;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hp.tx_ready_pin_n <= 1'b1;
    end else begin
      hp.tx_ready_pin_n <= (tx_cnt_next == TX_DEPTH[TX_AW:0]); // R9
    end
  end

  // ****************************************
  // transmit word parser
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      txp_reg          <= TXP_LEN;
      tx_left_reg      <= '0;
      tx_out_len       <= '0;
      tx_out_dest_mask <= '0;
      tx_out_valid     <= 1'b0;
      tx_out_data      <= '0;
      tx_out_last      <= 1'b0;
    end else begin
      if (tx_out_valid && tx_out_ready) begin
        tx_out_valid <= 1'b0;
      end
      if (tx_pop) begin
        case (txp_reg)
          TXP_LEN: begin
            tx_out_len  <= tx_head[LEN_MSB:0]; // R3 R17
            tx_left_reg <= 14'((17'(tx_head[LEN_MSB:0]) + 17'd3) >> 2);
            txp_reg     <= TXP_MASK;
          end
          TXP_MASK: begin
            tx_out_dest_mask <= normal_forward ? ZERO_WORD : tx_head; // R20
            txp_reg          <= (tx_left_reg == '0) ? TXP_LEN : TXP_DATA;
          end
          default: begin
            tx_out_valid <= 1'b1;
            tx_out_data  <= byte_swap(tx_head, big_endian); // R16 R4
            tx_out_last  <= (tx_left_reg == 14'd1);
            tx_left_reg  <= tx_left_reg - 14'd1;
            if (tx_left_reg == 14'd1) begin
              txp_reg <= TXP_LEN;
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // receive fifo, bit 32 marks the status word
  // ****************************************
  logic [32:0]      rx_mem [RX_DEPTH];
  logic [RX_AW-1:0] rx_wp_reg;
  logic [RX_AW-1:0] rx_rp_reg;
  logic [RX_AW:0]   rx_cnt_reg;
  logic [RX_AW:0]   rx_cnt_next;
  logic             rx_push;
  logic             rx_pop;
  logic [32:0]      rx_wword;
  rx_build_t        rxb_reg;
  rx_build_t        rxb_next;
  logic             rx_room;
  logic             rx_beat;
  logic             pay_odd_reg;
  logic [31:0]      stat_reg;

  assign rx_room = (rx_cnt_reg != RX_DEPTH[RX_AW:0]);
  assign rx_beat = rx_in_valid && rx_in_ready;
  assign rx_pop  = hp.rd_en && (rx_cnt_reg != '0); // R22 R1

  always_comb begin
    rx_push  = 1'b0;
    rx_wword = {1'b0, ZERO_WORD};
    rxb_next = rxb_reg;
    case (rxb_reg)
      RXB_HEAD: begin
        if (rx_in_valid && rx_room) begin
          rx_push  = 1'b1;
          rx_wword = {1'b0, 8'h00, rx_in_info[INFO_MSB:0]}; // R19 R17
          rxb_next = RXB_DATA;
        end
      end
      RXB_DATA: begin
        if (rx_beat) begin
          rx_push  = 1'b1;
          rx_wword = {1'b0, byte_swap(rx_in_data, big_endian)}; // R16 R7
          if (rx_in_last) begin
            // an odd payload count leaves header+payload+status odd, so pad once
            rxb_next = (pad_64 && !pay_odd_reg) ? RXB_PAD : RXB_STAT; // R13
          end
        end
      end
      RXB_PAD: begin
        if (rx_room) begin
          rx_push  = 1'b1;
          rxb_next = RXB_STAT;
        end
      end
      default: begin
        if (rx_room) begin
          rx_push  = 1'b1;
          rx_wword = {1'b1, stat_reg}; // R8
          rxb_next = RXB_HEAD;
        end
      end
    endcase
  end

  assign rx_cnt_next = rx_cnt_reg + {{RX_AW{1'b0}}, rx_push} - {{RX_AW{1'b0}}, rx_pop};

  always_ff @(posedge clk) begin
    if (rx_push) begin
      rx_mem[rx_wp_reg] <= rx_wword;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_wp_reg   <= '0;
      rx_rp_reg   <= '0;
      rx_cnt_reg  <= '0;
      rxb_reg     <= RXB_HEAD;
      pay_odd_reg <= 1'b0;
      stat_reg    <= '0;
      rx_in_ready <= 1'b0;
    end else begin
      rx_wp_reg   <= rx_wp_reg + RX_AW'(rx_push);
      rx_rp_reg   <= rx_rp_reg + RX_AW'(rx_pop);
      rx_cnt_reg  <= rx_cnt_next;
      rxb_reg     <= rxb_next;
      rx_in_ready <= (rxb_next == RXB_DATA) && (rx_cnt_next != RX_DEPTH[RX_AW:0]);
      if (rxb_reg == RXB_HEAD) begin
        pay_odd_reg <= 1'b0;
      end else if (rx_beat) begin
        pay_odd_reg <= !pay_odd_reg;
      end
      if (rx_beat && rx_in_last) begin
        stat_reg <= {26'h0, 1'b0, rx_in_invalid_bytes, rx_in_err}; // R18
      end
    end
  end

  // ****************************************
  // host read port
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      hp.rd_data        <= '0;
      hp.rd_valid       <= 1'b0;
      hp.rx_end_pin     <= 1'b0;
      hp.rx_request_pin <= 1'b0;
    end else begin
      hp.rd_valid       <= hp.rd_en;
      hp.rx_request_pin <= (rx_cnt_next != '0); // R5 R11 R14 R15
      if (rx_pop) begin
        hp.rd_data    <= rx_mem[rx_rp_reg][31:0];
        hp.rx_end_pin <= rx_mem[rx_rp_reg][32]; // R6 R12
      end else begin
        hp.rd_data    <= hp.rd_en ? ZERO_WORD : hp.rd_data; // R22
        hp.rx_end_pin <= 1'b0;
      end
    end
  end

endmodule : packet_port_device

/* hdl/packet_host_ctrl.sv */
// host end: apb slave registers that move words through the packet port
`timescale 1ns/1ps
module packet_host_ctrl
  import pkt_port_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // device side
  host_packet_port_if.host hp
);

  host_state_t state_reg;
  logic        eot_reg;
  logic        access;

  assign access = psel && penable && !pready;

  // ****************************************
  // request handling
  // ****************************************
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_reg  <= HC_IDLE;
      pready     <= 1'b0;
      pslverr    <= 1'b0;
      prdata     <= '0;
      eot_reg    <= 1'b0;
      hp.wr_en   <= 1'b0;
      hp.wr_data <= '0;
      hp.rd_en   <= 1'b0;
    end else begin
      pready   <= 1'b0;
      pslverr  <= 1'b0;
      hp.wr_en <= 1'b0;
      hp.rd_en <= 1'b0;
      case (state_reg)
        HC_IDLE: begin
          if (access) begin
            if (paddr == TX_FIFO_OFS && pwrite) begin
              if (!hp.tx_ready_pin_n) begin // R2 R10
                hp.wr_en   <= 1'b1;
                hp.wr_data <= pwdata; // R3
                pready     <= 1'b1;
              end
            end else if (paddr == RX_FIFO_OFS && !pwrite) begin
              if (hp.rx_request_pin) begin // R5 R11
                hp.rd_en  <= 1'b1;
                state_reg <= HC_READ;
              end else begin
                prdata <= ZERO_WORD;
                pready <= 1'b1;
              end
            end else if (paddr == STATUS_OFS && !pwrite) begin
              prdata               <= ZERO_WORD;
              prdata[ST_TX_READY_FLAG_BIT] <= !hp.tx_ready_pin_n;
              prdata[ST_RX_READY_FLAG_BIT] <= hp.rx_request_pin;
              prdata[ST_EOT_BIT]   <= eot_reg; // R6
              pready               <= 1'b1;
            end else begin
              prdata  <= ZERO_WORD;
              pready  <= 1'b1;
              pslverr <= 1'b1;
            end
          end
        end
        default: begin
          if (hp.rd_valid) begin
            prdata    <= hp.rd_data;
            eot_reg   <= hp.rx_end_pin; // R12
            pready    <= 1'b1;
            state_reg <= HC_IDLE;
          end
        end
      endcase
    end
  end

endmodule : packet_host_ctrl

/* tb/pkt_port_chk.sv */
// assertions on the word port between the two ends
`timescale 1ns/1ps
module pkt_port_chk (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // word port
  input wire logic        wr_en,
  input wire logic        rd_en,
  input wire logic [31:0] rd_data,
  input wire logic        rd_valid,
  input wire logic        tx_ready_pin_n,
  input wire logic        rx_request_pin,
  input wire logic        rx_end_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // next delivered word opens a frame
  logic hdr_next_reg;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) hdr_next_reg <= 1'b1;
    else if (rd_valid) hdr_next_reg <= rx_end_pin;
  end

  a_valid_follows: assert property (rd_en |=> rd_valid)
    else $error("rd_valid missing after rd_en");
  a_valid_cause: assert property (rd_valid |-> $past(rd_en))
    else $error("rd_valid without rd_en");
  a_end_with_valid: assert property (rx_end_pin |-> rd_valid)
    else $error("end pin without delivered word");
  a_end_pulse: assert property (rx_end_pin ##1 1'b1 |-> !rx_end_pin)
    else $error("end pin longer than one cycle");
  a_wr_gated: assert property (wr_en |-> !$past(tx_ready_pin_n))
    else $error("write while tx not ready");
  a_rd_gated: assert property (rd_en |-> $past(rx_request_pin))
    else $error("read while no request");
  a_req_falls: assert property ($fell(rx_request_pin) |-> rd_valid || $past(rd_valid))
    else $error("request fell without a read");
  a_status_upper: assert property (rx_end_pin |-> rd_data[31:6] == 26'h0)
    else $error("status word upper bits set");
  a_header_upper: assert property (rd_valid && hdr_next_reg |-> rd_data[31:24] == 8'h00 && !rx_end_pin)
    else $error("header word malformed");
endmodule : pkt_port_chk

/* tb/cpu_packet_port_tb.sv */
// self-checking bench for both ends of the host packet port
`timescale 1ns/1ps
module cpu_packet_port_tb import pkt_port_pkg::*;;
  logic        clk = 1'b0, reset = 1'b1;
  logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr, perr;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rdat, w, tx_out_data, tx_out_dest_mask;
  logic        big_endian = 1'b1, pad_64 = 1'b0, normal_forward = 1'b0;
  logic        tx_out_valid, tx_out_ready = 1'b0, tx_out_last;
  logic [15:0] tx_out_len;
  logic        rx_in_valid = 1'b0, rx_in_ready, rx_in_last = 1'b0;
  logic [31:0] rx_in_data = 32'h0;
  logic [1:0]  rx_in_invalid_bytes = 2'h0;
  logic [23:0] rx_in_info = 24'h0;
  logic [2:0]  rx_in_err = 3'h0;
  logic [32:0] txq[$];
  int          n_mismatch = 0, n_checks = 0;

  host_packet_port_if hp ();
  always #2.5 clk = ~clk;

  packet_host_ctrl u_packet_host_ctrl (.clk, .reset, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hp(hp.host));
  packet_port_device u_packet_port_device (.clk, .reset, .hp(hp.dev), .big_endian, .pad_64,
    .normal_forward, .tx_out_valid, .tx_out_ready, .tx_out_data, .tx_out_last, .tx_out_len,
    .tx_out_dest_mask, .rx_in_valid, .rx_in_ready, .rx_in_data, .rx_in_last,
    .rx_in_invalid_bytes, .rx_in_info, .rx_in_err);
  pkt_port_chk u_pkt_port_chk (.clk, .reset, .wr_en(hp.wr_en), .rd_en(hp.rd_en),
    .rd_data(hp.rd_data), .rd_valid(hp.rd_valid), .tx_ready_pin_n(hp.tx_ready_pin_n),
    .rx_request_pin(hp.rx_request_pin), .rx_end_pin(hp.rx_end_pin));

  always @(posedge clk) if (tx_out_valid && tx_out_ready) txq.push_back({tx_out_last, tx_out_data});

  // ****************************************
  // checking and closing
  // ****************************************
  task automatic conclude();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : conclude

  task automatic ck(input logic [32:0] seen, input logic [32:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : ck

  task automatic tmo(input logic hit);
    if (hit) begin
      n_mismatch++;
      conclude();
    end
  endtask : tmo

  // ****************************************
  // apb master and frame source
  // ****************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 300);
    tmo(k >= 300);
    rdat = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    ck(rdat, exp);
  endtask : rd

  task automatic rx_frame(input logic [23:0] info, input int n, input logic [1:0] inv,
                          input logic [2:0] err);
    int k;
    for (int i = 0; i < n; i++) begin
      rx_in_valid <= 1'b1;
      rx_in_info <= info;
      rx_in_data <= 32'h44332211 + 32'(i);
      rx_in_last <= (i == n - 1);
      rx_in_invalid_bytes <= inv;
      rx_in_err <= err;
      k = 0;
      do begin
        @(posedge clk);
        k++;
      end while (rx_in_ready !== 1'b1 && k < 50);
      tmo(k >= 50);
    end
    rx_in_valid <= 1'b0;
    rx_in_last <= 1'b0;
  endtask : rx_frame

  task automatic waitq(input int n);
    int k;
    k = 0;
    while (txq.size() < n && k < 400) begin
      @(posedge clk);
      k++;
    end
    tmo(k >= 400);
  endtask : waitq

  // ****************************************
  // scenarios
  // ****************************************
  initial begin
    repeat (12) @(posedge clk);
    reset <= 1'b0;
    repeat (2) @(posedge clk);
    ck(hp.tx_ready_pin_n, 1'b0);
    rd(STATUS_OFS, 32'h1);
    rd(8'h0c, 32'h0);
    ck(perr, 1'b1);
    apb(1'b1, STATUS_OFS, 32'h0);
    ck(perr, 1'b1);
    rd(RX_FIFO_OFS, 32'h0);
    // big endian frame of 80 bytes with the switch stalled
    for (int i = 0; i < 22; i++) begin
      if (!tx_out_ready) begin
        apb(1'b0, STATUS_OFS, 32'h0);
        if (!rdat[ST_TX_READY_FLAG_BIT]) begin
          ck(hp.tx_ready_pin_n, 1'b1);
          ck(i > 15, 1'b1);
          tx_out_ready <= 1'b1;
        end
      end
      apb(1'b1, TX_FIFO_OFS, i == 0 ? 32'h50 : i == 1 ? 32'h00a50003 : 32'h10111213 + 32'(i - 2));
    end
    ck(tx_out_ready, 1'b1);
    waitq(20);
    foreach (txq[j]) begin
      w = 32'h10111213 + 32'(j);
      ck(txq[j], {j == 19, w[7:0], w[15:8], w[23:16], w[31:24]});
    end
    ck(tx_out_len, 16'h50);
    ck(tx_out_dest_mask, 32'h00a50003);
    txq.delete();
    normal_forward <= 1'b1;
    big_endian <= 1'b0;
    apb(1'b1, TX_FIFO_OFS, 32'h4);
    apb(1'b1, TX_FIFO_OFS, 32'hffffffff);
    apb(1'b1, TX_FIFO_OFS, 32'h10111213);
    waitq(1);
    ck(txq[0], {1'b1, 32'h10111213});
    ck(tx_out_dest_mask, 32'h0);
    // little endian receive, no extra padding
    rx_frame(24'hc5a123, 2, 2'h2, 3'h5);
    rd(RX_FIFO_OFS, 32'h00c5a123);
    rd(STATUS_OFS, 32'h3);
    rd(RX_FIFO_OFS, 32'h44332211);
    rd(RX_FIFO_OFS, 32'h44332212);
    rd(RX_FIFO_OFS, 32'h15);
    rd(STATUS_OFS, 32'h5);
    // big endian receive padded to 64 bits
    pad_64 <= 1'b1;
    big_endian <= 1'b1;
    rx_frame(24'h8f7001, 1, 2'h1, 3'h2);
    rd(RX_FIFO_OFS, 32'h008f7001);
    rd(RX_FIFO_OFS, 32'h11223344);
    rd(RX_FIFO_OFS, 32'h0);
    rd(RX_FIFO_OFS, 32'h0a);
    rd(RX_FIFO_OFS, 32'h0);
    conclude();
  end
endmodule : cpu_packet_port_tb
